// File: dv/irad_decoder_assertions.sv
// Checker: map and timing properties of the window decoder
`timescale 1ns/100ps
module irad_decoder_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire irad_pkg::irad_req_type req,
  input wire irad_pkg::irad_cfg_type cfg,
  input wire irad_pkg::irad_resp_type resp,
  input wire logic mapLocked
);
  import irad_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence coreWin;
    req.valid && req.src == IRAD_SRC_CORE && !req.virt32 && req.addr[35:16] == DEFAULT_BASE;
  endsequence
  sel_onehot_a: assert property ($onehot0(resp.sel)) else $error("two selects");
  reserved_low_a: assert property (
    coreWin ##0 !req.addr[15] |=> !resp.hit && resp.sel == '0)
    else $error("reserved offset selected");
  sdram_sel_a: assert property (
    coreWin ##0 req.addr[15:12] == 4'h8 |=> resp.sel == 16'h0001)
    else $error("sdram region missed");
  dma_split_a: assert property (
    coreWin ##0 req.addr[15:12] == 4'hB |=>
    resp.sel[SEL_DMA_B] == $past(req.addr[11]) && resp.sel[SEL_DMA_A] == !$past(req.addr[11]))
    else $error("dma split wrong");
  par_io_sel_a: assert property (
    coreWin ##0 req.addr[15:4] == 12'hF50 |=> resp.sel == 16'h1000)
    else $error("parallel port missed");
  lane_pick_a: assert property (
    coreWin ##0 req.addr[15:3] == 13'h1008 && req.size == IRAD_SIZE_W32 |=>
    resp.lane == (($past(req.addr[2]) ^ $past(cfg.bigEndian)) ? IRAD_LANE_HIGH : IRAD_LANE_LOW))
    else $error("half lane wrong");
  full_dword_a: assert property (
    coreWin ##0 req.addr[15:0] == SDRAM_COMMAND && req.size == IRAD_SIZE_W64 |=>
    resp.reg64 && resp.sizeOk && resp.lane == IRAD_LANE_BOTH)
    else $error("64-bit access wrong");
  pci_cfg_le_a: assert property (
    req.valid && req.src == IRAD_SRC_PCI_CFG && req.addr[15:12] == 4'hD |=>
    resp.littleEndian && resp.sizeOk)
    else $error("config cycle not little");
  virt_alias_a: assert property (
    req.valid && req.src == IRAD_SRC_CORE && req.virt32 && req.addr[31:12] == 20'hFF1F8 |=>
    resp.sel == 16'h0001)
    else $error("virt alias");
  reloc_alias_a: assert property (
    req.valid && req.src == IRAD_SRC_CORE && !req.virt32 && cfg.relocEn &&
    req.addr[35:16] == cfg.relocBase && req.addr[15:8] == 8'hF1 |=> resp.sel == 16'h0100)
    else $error("relocated alias");
  reset_clear_a: assert property (disable iff (1'b0) rst |-> resp == '0 && !mapLocked)
    else $error("output during reset");
endmodule // irad_decoder_assertions
bind irad_decoder irad_decoder_assertions irad_decoder_assertions_inst (.core_clk(core_clk),
  .rst(rst), .req(req), .cfg(cfg), .resp(resp), .mapLocked(mapLocked));

// File: dv/irad_requester_model.sv
// Requester model: core or PCI side driving decoder requests
`timescale 1ns/100ps
module irad_requester_model (
  input wire logic core_clk,
  input wire irad_pkg::irad_req_type nextReq,
  output irad_pkg::irad_req_type req
);
  import irad_pkg::*;
  logic [ADDR_W-1:0] lastAddr_q;
  logic [ADDR_W-1:0] lastAddr_d;
  always_comb begin
    lastAddr_d = nextReq.valid ? nextReq.addr : lastAddr_q;
    req = nextReq;
    // Idle bus never shows the stale address
    if (!nextReq.valid) begin
      req.addr = ~lastAddr_q;
    end
  end
  always_ff @(posedge core_clk) begin
    lastAddr_q <= lastAddr_d;
  end
endmodule // irad_requester_model

// File: dv/test_internal_register_address_decoder.sv
// Testbench: walks the window decoder through its address map
`timescale 1ns/100ps
module test_internal_register_address_decoder;
  import irad_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  irad_req_type nextReq = '0;
  irad_req_type req;
  irad_cfg_type cfg = '0;
  irad_resp_type resp;
  logic mapLocked;
  int num_errors = 0;
  int total_checks = 0;
  always #25 core_clk = ~core_clk;
  irad_requester_model irad_requester_model_inst (.core_clk(core_clk), .nextReq(nextReq),
    .req(req));
  irad_decoder irad_decoder_inst (.core_clk(core_clk), .rst(rst), .req(req), .cfg(cfg),
    .resp(resp), .mapLocked(mapLocked));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic access(input irad_src_type s, input logic v, input logic [35:0] a,
      input irad_size_type z);
    nextReq = '{valid: 1'b1, src: s, virt32: v, addr: a, size: z};
    @(negedge core_clk);
  endtask
  task automatic t_regions;
    logic [15:0] offs [20] = '{16'h8000, 16'h8FFF, 16'h9FFF, 16'hA000, 16'hB7FF, 16'hB800,
      16'hD000, 16'hEFFF, 16'hF0FF, 16'hF100, 16'hF2FF, 16'hF300, 16'hF4FF, 16'hF50F,
      16'hF510, 16'hF6FF, 16'hF7FF, 16'h7FFF, 16'hC000, 16'hF800};
    int idx [20] = '{0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 13, 14, -1, -1, -1};
    logic [31:0] expSel;
    for (int i = 0; i < 20; i++) begin
      access(IRAD_SRC_CORE, 1'b0, {DEFAULT_BASE, offs[i]}, IRAD_SIZE_W32);
      expSel = (idx[i] < 0) ? 32'h0 : 32'h1 << idx[i];
      check("sel", expSel, resp.sel);
      check("hit", idx[i] >= 0, resp.hit);
    end
  endtask
  task automatic t_lanes;
    for (int e = 0; e < 2; e++) begin
      for (int h = 0; h < 2; h++) begin
        cfg.bigEndian = e[0];
        access(IRAD_SRC_CORE, 1'b0, {DEFAULT_BASE, 13'h1008, h[0], 2'h0}, IRAD_SIZE_W32);
        check("lane", (h[0] ^ e[0]) ? IRAD_LANE_HIGH : IRAD_LANE_LOW, resp.lane);
      end
    end
    access(IRAD_SRC_CORE, 1'b0, {DEFAULT_BASE, 16'h8058}, IRAD_SIZE_W64);
    check("dword", 32'hF, {resp.lane, resp.sizeOk, resp.reg64});
    access(IRAD_SRC_CORE, 1'b0, {DEFAULT_BASE, 16'h9038}, IRAD_SIZE_W64);
    check("ebus reg64", 1'b1, resp.reg64);
    access(IRAD_SRC_CORE, 1'b0, {DEFAULT_BASE, 16'hF000}, IRAD_SIZE_W64);
    check("narrow size", 1'b0, resp.sizeOk);
  endtask
  task automatic t_alias;
    cfg.relocEn = 1'b1;
    cfg.relocBase = 20'h12345;
    access(IRAD_SRC_CORE, 1'b0, 36'h1_2345_F100, IRAD_SIZE_W32);
    check("reloc sel", 32'h100, resp.sel);
    check("reloc offs", 32'hF100, resp.offs);
    access(IRAD_SRC_CORE, 1'b0, {DEFAULT_BASE, 16'hF100}, IRAD_SIZE_W32);
    check("default sel", 32'h100, resp.sel);
    access(IRAD_SRC_CORE, 1'b1, 36'h0_FF1F_8000, IRAD_SIZE_W32);
    check("virt sel", 32'h1, resp.sel);
    check("virt offs", 32'h8000, resp.offs);
    access(IRAD_SRC_CORE, 1'b0, 36'h0_4000_8000, IRAD_SIZE_W32);
    check("outside", 32'h0, {resp.hit, resp.sel});
    check("locked", 1'b1, mapLocked);
    rst = 1'b1;
    @(negedge core_clk);
    check("relock", 32'h0, mapLocked);
    check("reset sel", 32'h0, resp.sel);
    rst = 1'b0;
    cfg.relocEn = 1'b0;
  endtask
  task automatic t_pci;
    cfg.bigEndian = 1'b1;
    access(IRAD_SRC_PCI_TGT, 1'b0, 36'h0_0000_D000, IRAD_SIZE_W32);
    check("pci target", 32'h20, resp.sel);
    access(IRAD_SRC_PCI_CFG, 1'b0, 36'h0_0000_D004, IRAD_SIZE_OTHER);
    check("pci config", 32'h3, {resp.littleEndian, resp.sizeOk});
  endtask
  task automatic t_boot;
    access(IRAD_SRC_CORE, 1'b0, BOOT_LO, IRAD_SIZE_W32);
    check("boot rom", 1'b1, resp.bootHit);
    check("boot sel", 32'h8000, resp.sel);
    cfg.bootFromPci = 1'b1;
    access(IRAD_SRC_CORE, 1'b0, BOOT_LO, IRAD_SIZE_W32);
    check("boot pci", 1'b0, resp.bootHit);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
  initial begin
    rst <= 1'b1;
    repeat (8) @(negedge core_clk);
    check("reset", 32'h1, {resp, mapLocked} == '0);
    rst = 1'b0;
    t_regions();
    t_lanes();
    t_alias();
    t_pci();
    t_boot();
    nextReq.valid = 1'b0;
    @(negedge core_clk);
    summarize();
  end
endmodule // test_internal_register_address_decoder

// File: rtl/irad_decoder.sv
// Internal register window and peripheral region decoder
//
// How it works
// - Decode full 36-bit physical address space.
// - 64 KB window, default or pointer base.
// - Both bases reach the same register.
// - Core 32-bit uncached segment maps default window.
// - After reset only window and boot mapped.
// - Boot from external channel 0 or PCI.
// - Other spaces placed by their own controllers.
// - 64-bit registers take 64 or 32-bit halves.
// - Satellite config cycles any size, little-endian.
// - External PCI masters reach internal resources.
// - SDRAM, external bus, ECC 4 KB regions.
// - Two DMA units, 2 KB each.
// - PCI and chip configuration regions.
// - Three 256-byte timer regions.
// - Two serial ports, 16-byte parallel port.
// - Interrupt and audio link regions.
// - Reserved and unassigned ranges select nothing.
// - SDRAM channel, timing, command registers.
// - Eight external bus channel registers.
`timescale 1ns/100ps
module irad_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire irad_pkg::irad_req_type req,
  input wire irad_pkg::irad_cfg_type cfg,
  output irad_pkg::irad_resp_type resp,
  output logic mapLocked
);
  import irad_pkg::*;

  typedef enum logic [2:0] {
    IRAD_ST_BOOT = 3'b001,
    IRAD_ST_RUN = 3'b010,
    IRAD_ST_HOLD = 3'b100
  } irad_state_type;

  irad_state_type state_q, state_d;
  irad_resp_type resp_q, resp_d;

  logic [ADDR_W-1:0] physAddr;
  logic [BASE_W-1:0] addrBase;
  logic [OFFS_W-1:0] offs;
  logic defHit, relHit, inWindow, bootHit;
  logic [NUM_REGIONS-1:0] sel;
  logic reg64;
  logic sizeOk;
  irad_lane_type lane;
  logic le;

  // Core 32-bit uncached segment translation
  always_comb begin
    physAddr = req.addr;
    if (req.virt32 && req.src == IRAD_SRC_CORE && req.addr[31:0] >= KSEG_VIRT_LO &&
        req.addr[31:0] <= KSEG_VIRT_HI) begin
      physAddr = KSEG_PHYS_LO | {12'h000, 24'(req.addr[31:0] - KSEG_VIRT_LO)};
    end
  end

  assign addrBase = physAddr[ADDR_W-1:OFFS_W];
  assign offs = physAddr[OFFS_W-1:0];

  // Window hit at fixed base or pointer base
  always_comb begin
    defHit = (addrBase == DEFAULT_BASE);
    relHit = cfg.relocEn && (addrBase == cfg.relocBase);
    // PCI target and satellite config requests come already window relative
    inWindow = req.valid && (defHit || relHit || req.src != IRAD_SRC_CORE);
  end

  // Region comparators
  irad_region_match #(
    .LO(SDRAM_LO),
    .HI(SDRAM_HI)
  ) u_sdram_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_SDRAM])
  );

  irad_region_match #(
    .LO(EBUS_LO),
    .HI(EBUS_HI)
  ) u_ebus_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_EBUS])
  );

  irad_region_match #(
    .LO(ECC_LO),
    .HI(ECC_HI)
  ) u_ecc_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_ECC])
  );

  irad_region_match #(
    .LO(DMA_A_LO),
    .HI(DMA_A_HI)
  ) u_dma_a_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_DMA_A])
  );

  irad_region_match #(
    .LO(DMA_B_LO),
    .HI(DMA_B_HI)
  ) u_dma_b_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_DMA_B])
  );

  irad_region_match #(
    .LO(PCI_LO),
    .HI(PCI_HI)
  ) u_pci_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_PCI])
  );

  irad_region_match #(
    .LO(CFG_LO),
    .HI(CFG_HI)
  ) u_cfg_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_CFG])
  );

  irad_region_match #(
    .LO(TMR_A_LO),
    .HI(TMR_A_HI)
  ) u_tmr_a_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_TMR_A])
  );

  irad_region_match #(
    .LO(TMR_B_LO),
    .HI(TMR_B_HI)
  ) u_tmr_b_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_TMR_B])
  );

  irad_region_match #(
    .LO(TMR_C_LO),
    .HI(TMR_C_HI)
  ) u_tmr_c_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_TMR_C])
  );

  irad_region_match #(
    .LO(SER_A_LO),
    .HI(SER_A_HI)
  ) u_ser_a_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_SER_A])
  );

  irad_region_match #(
    .LO(SER_B_LO),
    .HI(SER_B_HI)
  ) u_ser_b_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_SER_B])
  );

  irad_region_match #(
    .LO(PARIO_LO),
    .HI(PARIO_HI)
  ) u_par_io_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_PARIO])
  );

  irad_region_match #(
    .LO(IRQ_LO),
    .HI(IRQ_HI)
  ) u_irq_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_IRQ])
  );

  irad_region_match #(
    .LO(AUDIO_LO),
    .HI(AUDIO_HI)
  ) u_audio_match (
    .inWindow(inWindow),
    .offs(offs),
    .hit(sel[SEL_AUDIO])
  );

  // Boot vector memory, the only other mapping after reset
  always_comb begin
    bootHit = req.valid && req.src == IRAD_SRC_CORE && !(defHit || relHit) &&
      physAddr >= BOOT_LO && physAddr <= BOOT_HI;
  end
  assign sel[SEL_BOOT] = bootHit;

  // Known 64-bit registers in SDRAM and external bus regions, plus the whole ECC and both DMA regions
  always_comb begin
    reg64 = 1'b0;
    if (sel[SEL_SDRAM] && (offs >= SDRAM_CHAN_FIRST && offs <= SDRAM_CHAN_LAST + 16'h0007 ||
        offs[15:3] == SDRAM_TIMING[15:3] || offs[15:3] == SDRAM_COMMAND[15:3])) begin
      reg64 = 1'b1;
    end
    if (sel[SEL_EBUS] && offs >= EBUS_CHAN_FIRST && offs <= EBUS_CHAN_LAST + 16'h0007) begin
      reg64 = 1'b1;
    end
    if (sel[SEL_ECC] || sel[SEL_DMA_A] || sel[SEL_DMA_B]) begin
      reg64 = 1'b1;
    end
  end

  // Size check and lane choice
  always_comb begin
    le = (req.src == IRAD_SRC_PCI_CFG) ? 1'b1 : !cfg.bigEndian;
    sizeOk = 1'b0;
    lane = IRAD_LANE_NONE;
    if (req.src == IRAD_SRC_PCI_CFG) begin
      sizeOk = 1'b1;
      lane = offs[WORD_HALF_BIT] ? IRAD_LANE_HIGH : IRAD_LANE_LOW;
    end else if (reg64) begin
      if (req.size == IRAD_SIZE_W64) begin
        sizeOk = 1'b1;
        lane = IRAD_LANE_BOTH;
      end else if (req.size == IRAD_SIZE_W32) begin
        sizeOk = 1'b1;
        lane = (offs[WORD_HALF_BIT] ^ le) ? IRAD_LANE_LOW : IRAD_LANE_HIGH;
      end
    end else if (req.size == IRAD_SIZE_W32) begin
      sizeOk = 1'b1;
      lane = IRAD_LANE_LOW;
    end
  end

  // Boot state: window and boot only until other maps are live
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IRAD_ST_BOOT: begin
        if (req.valid) begin
          state_d = IRAD_ST_RUN;
        end
      end
      IRAD_ST_RUN: begin
        if (cfg.relocEn) begin
          state_d = IRAD_ST_HOLD;
        end
      end
      IRAD_ST_HOLD: begin
        if (!cfg.relocEn) begin
          state_d = IRAD_ST_RUN;
        end
      end
      default: begin
        state_d = IRAD_ST_BOOT;
      end
    endcase
  end

  always_comb begin
    resp_d = '0;
    resp_d.hit = |sel;
    resp_d.sel = sel;
    resp_d.offs = offs;
    resp_d.lane = (|sel) ? lane : IRAD_LANE_NONE;
    resp_d.reg64 = reg64;
    resp_d.sizeOk = (|sel) && sizeOk;
    resp_d.littleEndian = le;
    resp_d.bootHit = bootHit && !cfg.bootFromPci;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= IRAD_ST_BOOT;
      resp_q <= '0;
    end else begin
      state_q <= state_d;
      resp_q <= resp_d;
    end
  end

  assign resp = resp_q;
  assign mapLocked = (state_q == IRAD_ST_HOLD);

endmodule // irad_decoder

// File: rtl/irad_pkg.sv
// Package: address map constants and carrier types for the register window decoder
package irad_pkg;

  localparam int ADDR_W = 36;
  localparam int OFFS_W = 16;
  localparam int BASE_W = ADDR_W - OFFS_W;
  localparam int NUM_REGIONS = 16;

  // Default window base, upper 20 bits of 0xF_FF1F_0000
  localparam logic [BASE_W-1:0] DEFAULT_BASE = 20'hFFF1F;
  // Core 32-bit uncached segment and its physical image
  localparam logic [31:0] KSEG_VIRT_LO = 32'hFF00_0000;
  localparam logic [31:0] KSEG_VIRT_HI = 32'hFF3F_FFFF;
  localparam logic [ADDR_W-1:0] KSEG_PHYS_LO = 36'hF_FF00_0000;

  // Region index encoding, one select bit each
  localparam int SEL_SDRAM = 0;
  localparam int SEL_EBUS = 1;
  localparam int SEL_ECC = 2;
  localparam int SEL_DMA_A = 3;
  localparam int SEL_DMA_B = 4;
  localparam int SEL_PCI = 5;
  localparam int SEL_CFG = 6;
  localparam int SEL_TMR_A = 7;
  localparam int SEL_TMR_B = 8;
  localparam int SEL_TMR_C = 9;
  localparam int SEL_SER_A = 10;
  localparam int SEL_SER_B = 11;
  localparam int SEL_PARIO = 12;
  localparam int SEL_IRQ = 13;
  localparam int SEL_AUDIO = 14;
  localparam int SEL_BOOT = 15;

  // Region bounds, inclusive offsets
  localparam logic [OFFS_W-1:0] SDRAM_LO = 16'h8000;
  localparam logic [OFFS_W-1:0] SDRAM_HI = 16'h8FFF;
  localparam logic [OFFS_W-1:0] EBUS_LO = 16'h9000;
  localparam logic [OFFS_W-1:0] EBUS_HI = 16'h9FFF;
  localparam logic [OFFS_W-1:0] ECC_LO = 16'hA000;
  localparam logic [OFFS_W-1:0] ECC_HI = 16'hAFFF;
  localparam logic [OFFS_W-1:0] DMA_A_LO = 16'hB000;
  localparam logic [OFFS_W-1:0] DMA_A_HI = 16'hB7FF;
  localparam logic [OFFS_W-1:0] DMA_B_LO = 16'hB800;
  localparam logic [OFFS_W-1:0] DMA_B_HI = 16'hBFFF;
  localparam logic [OFFS_W-1:0] PCI_LO = 16'hD000;
  localparam logic [OFFS_W-1:0] PCI_HI = 16'hDFFF;
  localparam logic [OFFS_W-1:0] CFG_LO = 16'hE000;
  localparam logic [OFFS_W-1:0] CFG_HI = 16'hEFFF;
  localparam logic [OFFS_W-1:0] TMR_A_LO = 16'hF000;
  localparam logic [OFFS_W-1:0] TMR_A_HI = 16'hF0FF;
  localparam logic [OFFS_W-1:0] TMR_B_LO = 16'hF100;
  localparam logic [OFFS_W-1:0] TMR_B_HI = 16'hF1FF;
  localparam logic [OFFS_W-1:0] TMR_C_LO = 16'hF200;
  localparam logic [OFFS_W-1:0] TMR_C_HI = 16'hF2FF;
  localparam logic [OFFS_W-1:0] SER_A_LO = 16'hF300;
  localparam logic [OFFS_W-1:0] SER_A_HI = 16'hF3FF;
  localparam logic [OFFS_W-1:0] SER_B_LO = 16'hF400;
  localparam logic [OFFS_W-1:0] SER_B_HI = 16'hF4FF;
  localparam logic [OFFS_W-1:0] PARIO_LO = 16'hF500;
  localparam logic [OFFS_W-1:0] PARIO_HI = 16'hF50F;
  localparam logic [OFFS_W-1:0] IRQ_LO = 16'hF510;
  localparam logic [OFFS_W-1:0] IRQ_HI = 16'hF6FF;
  localparam logic [OFFS_W-1:0] AUDIO_LO = 16'hF700;
  localparam logic [OFFS_W-1:0] AUDIO_HI = 16'hF7FF;

  // Named 64-bit registers inside the memory and bus controller regions
  localparam logic [OFFS_W-1:0] SDRAM_CHAN_FIRST = 16'h8000;
  localparam logic [OFFS_W-1:0] SDRAM_CHAN_LAST = 16'h8018;
  localparam logic [OFFS_W-1:0] SDRAM_TIMING = 16'h8040;
  localparam logic [OFFS_W-1:0] SDRAM_COMMAND = 16'h8058;
  localparam logic [OFFS_W-1:0] EBUS_CHAN_FIRST = 16'h9000;
  localparam logic [OFFS_W-1:0] EBUS_CHAN_LAST = 16'h9038;
  localparam logic [OFFS_W-1:0] REG_STRIDE = 16'h0008;
  localparam int WORD_HALF_BIT = 2;
  localparam int DWORD_BITS = 3;

  // Boot memory region, a plain default size of 4 MB ending just below 0x0_2000_0000
  localparam logic [ADDR_W-1:0] BOOT_LO = 36'h0_1FC0_0000;
  localparam logic [ADDR_W-1:0] BOOT_HI = 36'h0_1FFF_FFFF;

  typedef enum logic [1:0] {
    IRAD_SIZE_W32 = 2'h1,
    IRAD_SIZE_W64 = 2'h2,
    IRAD_SIZE_OTHER = 2'h0
  } irad_size_type;

  typedef enum logic [1:0] {
    IRAD_SRC_CORE = 2'h0,
    IRAD_SRC_PCI_TGT = 2'h1,
    IRAD_SRC_PCI_CFG = 2'h2
  } irad_src_type;

  typedef enum logic [1:0] {
    IRAD_LANE_BOTH = 2'h3,
    IRAD_LANE_HIGH = 2'h2,
    IRAD_LANE_LOW = 2'h1,
    IRAD_LANE_NONE = 2'h0
  } irad_lane_type;

  typedef struct packed {
    logic valid;
    irad_src_type src;
    logic virt32;
    logic [ADDR_W-1:0] addr;
    irad_size_type size;
  } irad_req_type;

  typedef struct packed {
    logic hit;
    logic [NUM_REGIONS-1:0] sel;
    logic [OFFS_W-1:0] offs;
    irad_lane_type lane;
    logic reg64;
    logic sizeOk;
    logic littleEndian;
    logic bootHit;
  } irad_resp_type;

  // Window and boot source control, driven from configuration logic outside
  typedef struct packed {
    logic relocEn;
    logic [BASE_W-1:0] relocBase;
    logic bigEndian;
    logic bootFromPci;
  } irad_cfg_type;

endpackage

// File: rtl/irad_region_match.sv
// Inclusive offset range comparator for one peripheral region
`timescale 1ns/100ps
module irad_region_match #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  input wire logic inWindow,
  input wire logic [15:0] offs,
  output logic hit
);
  always_comb begin
    hit = inWindow && (offs >= LO) && (offs <= HI);
  end
endmodule // irad_region_match
